// file: bench/csc_core_tb.sv
// Purpose: self-checking bench of the config and compensation core
// Assumes: scan millisecond shortened to 10 cycles
// Notes: shadow contents kept in sh, averages in avg
`timescale 1ns/1ps
`include "csc_defs.svh"
module csc_core_tb;
   logic clock = 1'b0, nrst = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
   logic [3:0] host_addr = 4'h0, nvm_addr_q;
   logic [7:0] host_wdata = 8'h00, host_rdata_q, nvm_wdata, nvm_rdata, afe_cycles_q, d, nv;
   logic [15:0] shift = 16'h0000, base = 16'h0000, afe_dac_q, afe_ticks, tick_avg_q, tick_diff_q;
   logic [1:0] op_mode_q;
   logic [2:0] afe_sel_q;
   logic load_done_q, nvm_rd, nvm_wr, nvm_ready, afe_pwr_en, afe_start_q, afe_done, proc_valid_q;
   logic comp_done_q, burn_done_q, chk_en = 1'b0, per_on = 1'b0;
   logic [7:0] sh [16] = '{default: 8'h00};
   logic signed [15:0] avg [8] = '{default: 16'h0000};
   logic signed [15:0] raw = 16'h0000, na;
   logic [31:0] seed = 32'hF813;
   int n_errors = 0, n_tests = 0, n_comp = 0, n_burn = 0, k;
   csc_core #(.MS_CYCLES(10)) i_csc_core (.clock, .nrst, .host_wr, .host_rd, .host_addr, .host_wdata,
      .host_rdata_q, .op_mode_q, .load_done_q, .nvm_rd, .nvm_wr, .nvm_addr_q, .nvm_wdata, .nvm_rdata,
      .nvm_ready, .afe_pwr_en, .afe_start_q, .afe_sel_q, .afe_cycles_q, .afe_dac_q, .afe_done, .afe_ticks,
      .proc_valid_q, .tick_avg_q, .tick_diff_q, .comp_done_q, .burn_done_q);
   csc_far_model i_csc_far_model (.clock, .nvm_rd, .nvm_wr, .nvm_addr_q, .nvm_wdata, .nvm_rdata,
      .nvm_ready, .afe_start_q, .afe_sel_q, .afe_cycles_q, .afe_dac_q, .shift, .afe_done, .afe_ticks);
   initial begin
      forever #25 clock = ~clock;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic close_out();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // two cycles per access so a strobe is never lowered and raised in one step
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      host_addr = a;
      host_wdata = v;
      host_wr = 1'b1;
      @(posedge clock) #2 host_wr = 1'b0;
      @(posedge clock) #2;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      host_addr = a;
      host_rd = 1'b1;
      @(posedge clock) #2 host_rd = 1'b0;
      v = host_rdata_q;
      @(posedge clock) #2;
   endtask
   task automatic await(input int sel, input int goal);
      int i;
      int cnt;
      for (i = 0; i < 20000; i++) begin
         cnt = sel == 0 ? n_comp : sel == 1 ? n_burn : int'(load_done_q === 1'b1);
         if (cnt >= goal) break;
         @(posedge clock) #2;
      end
      if (i == 20000) begin
         n_errors++;
         $display("MISMATCH wait %0d expected %0d seen timeout", sel, goal);
         close_out();
      end
   endtask
   always @(posedge clock) begin
      shift <= base + 16'(rnd() & 32'h3);
      if (comp_done_q === 1'b1) begin
         n_comp++;
         chk_en = !per_on;
         avg = '{default: 16'h0000};
      end
      if (burn_done_q === 1'b1) n_burn++;
      if (afe_start_q === 1'b1) begin
         chk("power", 16'h1, 16'(afe_pwr_en));
         chk("enable", 16'h1, 16'(sh[0][afe_sel_q]));
         chk("cycles", 16'(sh[1 + afe_sel_q]), 16'(afe_cycles_q));
      end
      if (afe_done === 1'b1) raw = afe_ticks;
      if (proc_valid_q === 1'b1 && chk_en) begin
         na = avg[afe_sel_q] + ((raw - avg[afe_sel_q]) >>> 3);
         chk("average", na, tick_avg_q);
         chk("difference", raw - na, tick_diff_q);
         avg[afe_sel_q] = na;
      end
   end
   initial begin
      sh = '{`CSC_Q_ENABLE, `CSC_Q_SENS, `CSC_Q_SENS, `CSC_Q_SENS, `CSC_Q_SENS, `CSC_Q_SENS, `CSC_Q_SENS,
         `CSC_Q_SENS, `CSC_Q_SENS, `CSC_Q_THR, `CSC_Q_THR, `CSC_Q_COMP_INT, `CSC_Q_SCAN_MS, 8'h00, 8'h00,
         `CSC_NVM_SIG};
      repeat (12) @(posedge clock);
      #2 nrst = 1'b1;
      await(2, 1);
      rd(`CSC_R_STATUS, d);
      chk("source defaults", 16'h1, 16'(d & 8'h03));
      await(0, 1);
      for (k = 8; k < 16; k++) begin
         rd(4'(k), d);
         chk("spare register", 16'h0, 16'(d));
      end
      wr(`CSC_R_MODE, 8'h09);
      chk("op mode", 16'h1, 16'(op_mode_q));
      chk_en = 1'b0;
      for (k = 0; k < 9; k++) begin
         nv = (k == 0) ? 8'h05 : 8'h08 + 8'(rnd() & 32'hF);
         wr(`CSC_R_SPM_ADDR, 4'(k));
         wr(`CSC_R_SPM_DATA, nv);
         sh[k] = nv;
      end
      wr(`CSC_R_CMD, 8'h03);
      await(1, 1);
      await(0, 2);
      for (k = 0; k < 16; k++) begin
         if (k < 13 || k == 15) chk("nvm word", 16'(sh[k]), 16'(i_csc_far_model.mem[k]));
      end
      nrst = 1'b0;
      chk_en = 1'b0;
      repeat (12) @(posedge clock);
      #2 nrst = 1'b1;
      await(2, 1);
      rd(`CSC_R_STATUS, d);
      chk("source nvm", 16'h3, 16'(d & 8'h03));
      await(0, 3);
      chk_en = 1'b0;
      base = 16'h00C8;
      await(0, 4);
      per_on = 1'b1;
      chk_en = 1'b0;
      wr(`CSC_R_MODE, 8'h04);
      wr(`CSC_R_SPM_ADDR, `CSC_P_COMP_INT);
      wr(`CSC_R_SPM_DATA, 8'h02);
      await(0, 6);
      close_out();
   end
endmodule // csc_core_tb

// file: bench/csc_far_model.sv
// Purpose: nvm array and sensing front end facing the core
// Assumes: same clock as the core
// Notes: nvm starts blank, so the first boot falls back to defaults
`timescale 1ns/1ps
module csc_far_model (
   input wire logic clock,
   input wire logic nvm_rd,
   input wire logic nvm_wr,
   input wire logic [3:0] nvm_addr_q,
   input wire logic [7:0] nvm_wdata,
   output logic [7:0] nvm_rdata,
   output logic nvm_ready,
   input wire logic afe_start_q,
   input wire logic [2:0] afe_sel_q,
   input wire logic [7:0] afe_cycles_q,
   input wire logic [15:0] afe_dac_q,
   input wire logic [15:0] shift,
   output logic afe_done,
   output logic [15:0] afe_ticks
);
   logic [7:0] mem [16] = '{default: 8'hFF};
   logic [1:0] wait_q = 2'h0;
   int busy_q = 0;
   initial begin
      nvm_rdata = 8'h00;
      nvm_ready = 1'b0;
      afe_done = 1'b0;
      afe_ticks = 16'h0000;
   end
   // slow on purpose: each write waits two cycles for acceptance
   always @(posedge clock) begin
      nvm_rdata <= nvm_rd ? mem[nvm_addr_q] : ~nvm_rdata;
      wait_q <= (nvm_wr && !nvm_ready) ? wait_q + 2'h1 : 2'h0;
      nvm_ready <= nvm_wr && !nvm_ready && wait_q == 2'h1;
      if (nvm_wr && nvm_ready) begin
         mem[nvm_addr_q] <= nvm_wdata;
      end
      // residue of sensor charge against the offset code
      afe_ticks <= (busy_q == 1) ? (16'h0014 + 16'(afe_sel_q)) * 16'(afe_cycles_q) + shift - afe_dac_q : ~afe_ticks;
      afe_done <= busy_q == 1;
      busy_q <= afe_start_q ? 2 + afe_cycles_q / 4 : (busy_q > 0 ? busy_q - 1 : 0);
   end
endmodule // csc_far_model

// file: hw/csc_core.sv
// Purpose: configuration source selection, shadow parameters, sensing sequence and offset compensation
// Assumes: host register strobes, nvm and sensing front end are logic on the same clock
// Notes: nvm read data valid one cycle after nvm_rd; nvm write held until nvm_ready
// Overview of operation
// - at power-up a valid non-volatile set becomes the configuration source
// - empty or invalid non-volatile set selects the fixed quick-start defaults
// - chosen set is copied to shadow memory; operation uses only shadow memory
// - any reset clears shadow state and reload runs automatically afterwards
// - quick-start defaults are read-only, nobody can modify them
// - host sees exactly 16 registers: status, mode control and access
// - in shadow access mode host writes overwrite shadow words and take effect
// - nvm programming: host writes shadow, then commands copy of shadow into nvm
// - compensation runs at every power-up, searching codes for zero ticks
// - compensation code is 16 bits per sensor, drives the offset converter
// - compensation codes are lost at shutdown and recomputed from scratch
// - average outside positive or negative noise threshold starts compensation
// - optional periodic compensation every configured number of scans
// - host can request compensation, e.g. after changing sensitivity
// - enabled sensors measured in turn, ticks stored, disabled ones skipped
// - sensitivity per sensor is the count of charge-accumulation cycles
// - front end powers down after the last sensor until the next scan
// - raw ticks low-pass filtered into an average, difference is raw minus average
// - sensing, processing and waiting repeat once per scan period
`timescale 1ns/1ps
`include "csc_defs.svh"
module csc_core #(
   parameter int MS_CYCLES = `CSC_MS_CYC
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [3:0] host_addr,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata_q,
   output logic [1:0] op_mode_q,
   output logic load_done_q,
   output logic nvm_rd,
   output logic nvm_wr,
   output logic [3:0] nvm_addr_q,
   output logic [7:0] nvm_wdata,
   input wire logic [7:0] nvm_rdata,
   input wire logic nvm_ready,
   output logic afe_pwr_en,
   output logic afe_start_q,
   output logic [2:0] afe_sel_q,
   output logic [7:0] afe_cycles_q,
   output logic [15:0] afe_dac_q,
   input wire logic afe_done,
   input wire logic [15:0] afe_ticks,
   output logic proc_valid_q,
   output logic [15:0] tick_avg_q,
   output logic [15:0] tick_diff_q,
   output logic comp_done_q,
   output logic burn_done_q
);
   csc_pkg::csc_state_t state_q, state_d;
   // local names of the package states, since nothing is imported
   localparam csc_pkg::csc_state_t S_CHK_RD = csc_pkg::S_CHK_RD;
   localparam csc_pkg::csc_state_t S_CHK_WR = csc_pkg::S_CHK_WR;
   localparam csc_pkg::csc_state_t S_CPY_RD = csc_pkg::S_CPY_RD;
   localparam csc_pkg::csc_state_t S_CPY_WR = csc_pkg::S_CPY_WR;
   localparam csc_pkg::csc_state_t S_IDLE = csc_pkg::S_IDLE;
   localparam csc_pkg::csc_state_t S_SEL = csc_pkg::S_SEL;
   localparam csc_pkg::csc_state_t S_RD = csc_pkg::S_RD;
   localparam csc_pkg::csc_state_t S_START = csc_pkg::S_START;
   localparam csc_pkg::csc_state_t S_WAIT = csc_pkg::S_WAIT;
   localparam csc_pkg::csc_state_t S_FILT = csc_pkg::S_FILT;
   localparam csc_pkg::csc_state_t S_STORE = csc_pkg::S_STORE;
   localparam csc_pkg::csc_state_t S_BURN_RD = csc_pkg::S_BURN_RD;
   localparam csc_pkg::csc_state_t S_BURN_WR = csc_pkg::S_BURN_WR;
   logic [3:0] cnt_q;
   logic src_nvm_q;
   logic [1:0] acc_q;
   logic [3:0] spm_ptr_q;
   logic burn_pend_q;
   logic comp_pend_q;
   logic comp_mode_q;
   logic [3:0] idx_q;
   logic [3:0] bit_q;
   logic [15:0] trial_q;
   logic [15:0] ticks_q;
   logic [15:0] ms_div_q;
   logic [7:0] ms_cnt_q;
   logic [7:0] scan_cnt_q;
   logic [7:0] cfg_en_q, cfg_pos_q, cfg_neg_q, cfg_int_q, cfg_scan_q;

   // quick-start set: a constant table with no write path at all
   function automatic logic [7:0] qsm_word(input logic [3:0] a);
      case (a)
         `CSC_P_ENABLE: qsm_word = `CSC_Q_ENABLE;
         `CSC_P_THR_POS: qsm_word = `CSC_Q_THR;
         `CSC_P_THR_NEG: qsm_word = `CSC_Q_THR;
         `CSC_P_COMP_INT: qsm_word = `CSC_Q_COMP_INT;
         `CSC_P_SCAN_MS: qsm_word = `CSC_Q_SCAN_MS;
         `CSC_P_SIG: qsm_word = `CSC_NVM_SIG;
         default: qsm_word = (a >= `CSC_P_SENS0 && a < `CSC_P_THR_POS) ? `CSC_Q_SENS : 8'h00;
      endcase
   endfunction

   // host decode
   wire host_mode_we = host_wr && host_addr == `CSC_R_MODE;
   wire host_ptr_we = host_wr && host_addr == `CSC_R_SPM_ADDR;
   wire host_spm_we = host_wr && host_addr == `CSC_R_SPM_DATA && load_done_q && acc_q != `CSC_ACC_OFF;
   wire host_cmd_we = host_wr && host_addr == `CSC_R_CMD && load_done_q;
   wire host_burn = host_cmd_we && host_wdata[`CSC_CMD_BURN] && acc_q == `CSC_ACC_NVM;
   wire host_comp = host_cmd_we && host_wdata[`CSC_CMD_COMP];

   // shadow memory ports
   wire boot_we = state_q == S_CPY_WR;
   wire spm_we = boot_we || host_spm_we;
   wire [3:0] spm_waddr = boot_we ? cnt_q : spm_ptr_q;
   wire [7:0] spm_wdata = boot_we ? (src_nvm_q ? nvm_rdata : qsm_word(cnt_q)) : host_wdata;
   wire spm_re = state_q == S_RD || state_q == S_BURN_RD;
   wire [3:0] spm_raddr = (state_q == S_BURN_RD) ? cnt_q : (`CSC_P_SENS0 + idx_q);
   wire [7:0] spm_rdata;

   // sensor loop decode
   wire [2:0] sidx = idx_q[2:0];
   wire scan_end = idx_q == 4'(`CSC_NSENS);
   wire sens_en = cfg_en_q[sidx];
   wire ms_tick = ms_div_q == 16'(MS_CYCLES - 1);
   wire [7:0] scan_len = (cfg_scan_q == 8'h00) ? 8'h01 : cfg_scan_q;
   wire scan_due = ms_tick && (ms_cnt_q + 8'h01 >= scan_len);
   wire tick_pos = !afe_ticks[15] && afe_ticks != 16'h0000;
   wire [15:0] bit_mask = 16'h0001 << bit_q;
   wire [15:0] trial_fin = tick_pos ? trial_q : (trial_q & ~bit_mask);
   wire comp_last = state_q == S_WAIT && afe_done && comp_mode_q && bit_q == 4'h0;
   wire periodic_due = cfg_int_q != 8'h00 && scan_cnt_q + 8'h01 >= cfg_int_q;

   // compensation code and average share one word per sensor
   wire [31:0] cm_rdata;
   wire [15:0] cm_comp = cm_rdata[31:16];
   wire [15:0] cm_avg = cm_rdata[15:0];
   wire filt_ov;
   wire [15:0] filt_avg, filt_diff;
   wire store_we = state_q == S_STORE && filt_ov;
   wire cm_we = store_we || comp_last;
   wire [31:0] cm_wdata = comp_last ? {trial_fin, 16'h0000} : {cm_comp, filt_avg};
   wire avg_high = $signed(filt_avg) > $signed({8'h00, cfg_pos_q});
   wire avg_low = $signed(filt_avg) < -$signed({8'h00, cfg_neg_q});
   wire thr_trip = store_we && (avg_high || avg_low);

   assign nvm_rd = (state_q == S_CHK_RD) || (state_q == S_CPY_RD && src_nvm_q);
   assign nvm_wr = state_q == S_BURN_WR;
   // the marker is forced so a burned set is always recognised as valid
   assign nvm_wdata = (cnt_q == `CSC_P_SIG) ? `CSC_NVM_SIG : spm_rdata;
   assign afe_pwr_en = state_q inside {S_SEL, S_RD, S_START, S_WAIT, S_FILT, S_STORE} && !scan_end;

   csc_mem #(.W(8), .D(`CSC_SPM_DEPTH), .AW(4)) u_shadow_param_memory (
      .clock(clock),
      .we(spm_we),
      .waddr(spm_waddr),
      .wdata(spm_wdata),
      .re(spm_re),
      .raddr(spm_raddr),
      .rdata_q(spm_rdata)
   );

   csc_mem #(.W(32), .D(`CSC_CM_DEPTH), .AW(3)) u_offset_comp_values (
      .clock(clock),
      .we(cm_we),
      .waddr(sidx),
      .wdata(cm_wdata),
      .re(state_q == S_RD),
      .raddr(sidx),
      .rdata_q(cm_rdata)
   );

   csc_tick_filter u_filter (
      .clock(clock),
      .nrst(nrst),
      .in_valid(state_q == S_FILT),
      .raw(ticks_q),
      .avg_in(cm_avg),
      .out_valid_q(filt_ov),
      .avg_q(filt_avg),
      .diff_q(filt_diff)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         S_CHK_RD: state_d = S_CHK_WR;
         S_CHK_WR: state_d = S_CPY_RD;
         S_CPY_RD: state_d = S_CPY_WR;
         S_CPY_WR: state_d = (cnt_q == `CSC_P_SIG) ? S_IDLE : S_CPY_RD;
         S_IDLE: begin
            if (burn_pend_q) begin
               state_d = S_BURN_RD;
            end else if (scan_due) begin
               state_d = S_SEL;
            end
         end
         S_SEL: begin
            if (scan_end) begin
               state_d = S_IDLE;
            end else if (sens_en) begin
               state_d = S_RD;
            end
         end
         S_RD: state_d = S_START;
         S_START: state_d = S_WAIT;
         S_WAIT: begin
            if (afe_done && !comp_mode_q) begin
               state_d = S_FILT;
            end else if (afe_done) begin
               state_d = (bit_q == 4'h0) ? S_SEL : S_START;
            end
         end
         S_FILT: state_d = S_STORE;
         S_STORE: state_d = filt_ov ? S_SEL : S_STORE;
         S_BURN_RD: state_d = S_BURN_WR;
         S_BURN_WR: begin
            if (nvm_ready) begin
               state_d = (cnt_q == `CSC_P_SIG) ? S_IDLE : S_BURN_RD;
            end
         end
         default: state_d = S_CHK_RD;
      endcase
   end

   // reset restarts at the validity check, so the reload is automatic
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q <= S_CHK_RD;
         cnt_q <= 4'h0;
         nvm_addr_q <= `CSC_P_SIG;
         src_nvm_q <= 1'b0;
         load_done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == S_CHK_WR) begin
            src_nvm_q <= nvm_rdata == `CSC_NVM_SIG;
            cnt_q <= 4'h0;
            nvm_addr_q <= 4'h0;
         end else if (state_q == S_CPY_WR || (state_q == S_BURN_WR && nvm_ready)) begin
            cnt_q <= cnt_q + 4'h1;
            nvm_addr_q <= cnt_q + 4'h1;
         end else if (state_q == S_IDLE) begin
            cnt_q <= 4'h0;
            nvm_addr_q <= 4'h0;
         end
         if (state_q == S_CPY_WR && cnt_q == `CSC_P_SIG) begin
            load_done_q <= 1'b1;
         end
      end
   end

   // operating copy of the shadow words that steer the scan loop
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cfg_en_q <= 8'h00;
         cfg_pos_q <= 8'h00;
         cfg_neg_q <= 8'h00;
         cfg_int_q <= 8'h00;
         cfg_scan_q <= 8'h00;
      end else if (spm_we) begin
         cfg_en_q <= (spm_waddr == `CSC_P_ENABLE) ? spm_wdata : cfg_en_q;
         cfg_pos_q <= (spm_waddr == `CSC_P_THR_POS) ? spm_wdata : cfg_pos_q;
         cfg_neg_q <= (spm_waddr == `CSC_P_THR_NEG) ? spm_wdata : cfg_neg_q;
         cfg_int_q <= (spm_waddr == `CSC_P_COMP_INT) ? spm_wdata : cfg_int_q;
         cfg_scan_q <= (spm_waddr == `CSC_P_SCAN_MS) ? spm_wdata : cfg_scan_q;
      end
   end

   // host registers; pending flags: set wins over the clear (burn clears in S_BURN_RD, compensation at end of run)
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         acc_q <= `CSC_ACC_OFF;
         op_mode_q <= 2'h0;
         spm_ptr_q <= 4'h0;
         burn_pend_q <= 1'b0;
         comp_pend_q <= 1'b1;
      end else begin
         if (host_mode_we) begin
            op_mode_q <= host_wdata[1:0];
            acc_q <= host_wdata[3:2];
         end
         if (host_ptr_we) begin
            spm_ptr_q <= host_wdata[3:0];
         end
         burn_pend_q <= host_burn || (burn_pend_q && state_q != S_BURN_RD);
         comp_pend_q <= host_comp || thr_trip || (state_q == S_SEL && scan_end && periodic_due)
            || (comp_pend_q && !(state_q == S_SEL && scan_end && comp_mode_q));
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         host_rdata_q <= 8'h00;
      end else if (host_rd) begin
         case (host_addr)
            `CSC_R_STATUS: host_rdata_q <= {4'h0, burn_pend_q, comp_pend_q, src_nvm_q, load_done_q};
            `CSC_R_MODE: host_rdata_q <= {4'h0, acc_q, op_mode_q};
            `CSC_R_SPM_ADDR: host_rdata_q <= {4'h0, spm_ptr_q};
            `CSC_R_DIFF_LO: host_rdata_q <= tick_diff_q[7:0];
            `CSC_R_DIFF_HI: host_rdata_q <= tick_diff_q[15:8];
            `CSC_R_SENS_IDX: host_rdata_q <= {5'h00, afe_sel_q};
            default: host_rdata_q <= 8'h00;
         endcase
      end
   end

   // scan timer: 1 ms enable pulse, then scan period count in idle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ms_div_q <= 16'h0000;
         ms_cnt_q <= 8'h00;
         scan_cnt_q <= 8'h00;
      end else begin
         ms_div_q <= (ms_tick || state_q != S_IDLE) ? 16'h0000 : ms_div_q + 16'h0001;
         if (state_q != S_IDLE || scan_due) begin
            ms_cnt_q <= 8'h00;
         end else if (ms_tick) begin
            ms_cnt_q <= ms_cnt_q + 8'h01;
         end
         if (state_q == S_SEL && scan_end) begin
            scan_cnt_q <= (comp_mode_q || periodic_due) ? 8'h00 : scan_cnt_q + 8'h01;
         end
      end
   end

   // sensor walk and successive approximation of the offset code
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         idx_q <= 4'h0;
         comp_mode_q <= 1'b0;
         bit_q <= `CSC_COMP_MSB;
         trial_q <= `CSC_COMP_START;
         ticks_q <= 16'h0000;
      end else begin
         if (state_q == S_IDLE && scan_due) begin
            idx_q <= 4'h0;
            comp_mode_q <= comp_pend_q;
         end else if (state_q == S_SEL && !scan_end && !sens_en) begin
            idx_q <= idx_q + 4'h1;
         end else if ((state_q == S_STORE && filt_ov) || comp_last) begin
            idx_q <= idx_q + 4'h1;
         end
         if (state_q == S_RD) begin
            bit_q <= `CSC_COMP_MSB;
            trial_q <= `CSC_COMP_START;
         end else if (state_q == S_WAIT && afe_done && comp_mode_q && bit_q != 4'h0) begin
            bit_q <= bit_q - 4'h1;
            trial_q <= trial_fin | (bit_mask >> 1);
         end
         if (state_q == S_WAIT && afe_done) begin
            ticks_q <= afe_ticks;
         end
      end
   end

   // front end drive and processed outputs
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         afe_start_q <= 1'b0;
         afe_sel_q <= 3'h0;
         afe_cycles_q <= 8'h00;
         afe_dac_q <= 16'h0000;
         proc_valid_q <= 1'b0;
         tick_avg_q <= 16'h0000;
         tick_diff_q <= 16'h0000;
         comp_done_q <= 1'b0;
         burn_done_q <= 1'b0;
      end else begin
         afe_start_q <= state_q == S_START;
         if (state_q == S_START) begin
            afe_sel_q <= sidx;
            afe_cycles_q <= spm_rdata;
            afe_dac_q <= comp_mode_q ? trial_q : cm_comp;
         end
         proc_valid_q <= store_we;
         if (store_we) begin
            tick_avg_q <= filt_avg;
            tick_diff_q <= filt_diff;
         end
         comp_done_q <= state_q == S_SEL && scan_end && comp_mode_q;
         burn_done_q <= state_q == S_BURN_WR && nvm_ready && cnt_q == `CSC_P_SIG;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   boot_nvm_a: assert property (state_q == S_CHK_WR && nvm_rdata == `CSC_NVM_SIG |=> src_nvm_q)
      else $error("valid nvm set not selected");
   boot_qsm_a: assert property (state_q == S_CHK_WR && nvm_rdata != `CSC_NVM_SIG |=> !src_nvm_q)
      else $error("invalid nvm set selected");
   load_copy_a: assert property ($rose(load_done_q) |-> $past(state_q == S_CPY_WR && cnt_q == `CSC_P_SIG))
      else $error("load done without full copy");
   early_host_a: assert property (!load_done_q |-> !host_spm_we && !burn_pend_q)
      else $error("host access before load");
   burn_mode_a: assert property ($rose(burn_pend_q) |-> $past(acc_q) == `CSC_ACC_NVM)
      else $error("burn outside nvm mode");
   boot_comp_a: assert property ($rose(load_done_q) |-> comp_pend_q ##1 comp_pend_q)
      else $error("no compensation after power-up");
   comp_seed_a: assert property (afe_start_q && comp_mode_q && $past(bit_q) == `CSC_COMP_MSB
      && $past(state_q, 2) == S_RD |-> afe_dac_q == `CSC_COMP_START)
      else $error("compensation search not seeded at msb");
   skip_off_a: assert property (afe_start_q |-> cfg_en_q[afe_sel_q])
      else $error("disabled sensor measured");
   idle_pwr_a: assert property (state_q == S_IDLE |-> !afe_pwr_en && !afe_start_q)
      else $error("front end powered while idle");
   thr_trip_a: assert property (thr_trip |=> comp_pend_q)
      else $error("threshold crossing did not request compensation");
   proc_out_a: assert property (proc_valid_q |-> $past(filt_ov) && tick_diff_q == $past(filt_diff))
      else $error("difference output not from filter");

   boot_nvm_c: cover property ($rose(load_done_q) && src_nvm_q);
   comp_run_c: cover property (comp_done_q);
   burn_run_c: cover property (burn_done_q);
   proc_run_c: cover property (proc_valid_q && !comp_mode_q);
endmodule // csc_core

// file: hw/csc_mem.sv
// Purpose: small simple dual port memory with registered read data
// Assumes: write and read may happen in the same cycle
// Notes: contents are not reset; owners reload them after reset
`timescale 1ns/1ps
module csc_mem #(
   parameter int W = 8,
   parameter int D = 16,
   parameter int AW = 4
) (
   input wire logic clock,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata_q
);
   logic [W-1:0] mem_q [D];

   always_ff @(posedge clock) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
      if (re) begin
         rdata_q <= mem_q[raddr];
      end
   end
endmodule // csc_mem

// file: hw/csc_tick_filter.sv
// Purpose: first-order low pass of raw ticks and the raw-minus-average difference
// Assumes: one sample in, result one cycle later
// Notes: average moves by 1/8 of the error per sample
`timescale 1ns/1ps
`include "csc_defs.svh"
module csc_tick_filter (
   input wire logic clock,
   input wire logic nrst,
   input wire logic in_valid,
   input wire logic [15:0] raw,
   input wire logic [15:0] avg_in,
   output logic out_valid_q,
   output logic [15:0] avg_q,
   output logic [15:0] diff_q
);
   logic signed [16:0] delta;
   logic signed [16:0] step;
   logic signed [16:0] sum;
   logic signed [16:0] diff_w;

   assign delta = $signed({raw[15], raw}) - $signed({avg_in[15], avg_in});
   assign step = delta >>> `CSC_AVG_SHIFT;
   // sum lies between avg_in and raw, so 16 bits always hold it
   assign sum = $signed({avg_in[15], avg_in}) + step;
   assign diff_w = $signed({raw[15], raw}) - sum;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         out_valid_q <= 1'b0;
         avg_q <= 16'h0000;
         diff_q <= 16'h0000;
      end else begin
         out_valid_q <= in_valid;
         if (in_valid) begin
            avg_q <= sum[15:0];
            diff_q <= diff_w[15:0];
         end
      end
   end
endmodule // csc_tick_filter

// file: pkg/csc_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the config and compensation block
// Assumes: 20 MHz clock, 8 sensors, 16-word shadow parameter memory
// Notes: shadow word layout and host register map are shared by design and bench
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH
`define CSC_NSENS 8
`define CSC_SPM_DEPTH 16
`define CSC_CM_DEPTH 8
// arbitrary marker meaning "parameter memory holds a valid set"
`define CSC_NVM_SIG 8'hA5
// shadow parameter word addresses
`define CSC_P_ENABLE 4'h0
`define CSC_P_SENS0 4'h1
`define CSC_P_THR_POS 4'h9
`define CSC_P_THR_NEG 4'hA
`define CSC_P_COMP_INT 4'hB
`define CSC_P_SCAN_MS 4'hC
`define CSC_P_SIG 4'hF
// quick-start default values
`define CSC_Q_ENABLE 8'hFF
`define CSC_Q_SENS 8'h10
`define CSC_Q_THR 8'h20
`define CSC_Q_COMP_INT 8'h00
`define CSC_Q_SCAN_MS 8'h1E
// host register map, 16 registers
`define CSC_R_STATUS 4'h0
`define CSC_R_MODE 4'h1
`define CSC_R_SPM_ADDR 4'h2
`define CSC_R_SPM_DATA 4'h3
`define CSC_R_CMD 4'h4
`define CSC_R_DIFF_LO 4'h5
`define CSC_R_DIFF_HI 4'h6
`define CSC_R_SENS_IDX 4'h7
`define CSC_CMD_BURN 0
`define CSC_CMD_COMP 1
`define CSC_ACC_OFF 2'h0
`define CSC_ACC_NVM 2'h2
// compensation and filtering
`define CSC_COMP_MSB 4'hF
`define CSC_COMP_START 16'h8000
`define CSC_AVG_SHIFT 3
// timing
`define CSC_MS_NS 1000000
`define CSC_CLK_NS 50
`define CSC_MS_CYC (`CSC_MS_NS / `CSC_CLK_NS)
`endif

// file: pkg/csc_pkg.sv
// Purpose: types of the config and compensation block
// Assumes: nothing beyond the defs header
// Notes: constants live in csc_defs.svh
package csc_pkg;
   typedef enum logic [3:0] {
      S_CHK_RD, S_CHK_WR, S_CPY_RD, S_CPY_WR, S_IDLE, S_SEL, S_RD,
      S_START, S_WAIT, S_FILT, S_STORE, S_BURN_RD, S_BURN_WR
   } csc_state_t;
   typedef logic signed [15:0] csc_tick_t;
endpackage
